// ### design/cab_pkg.sv
// shared types and constants for the arithmetic and branch execute unit
package cab_pkg;

  // operation codes presented by the decoder
  typedef enum logic [5:0] {
    CAB_OP_NOP        = 6'h00,
    CAB_OP_ADD        = 6'h01,
    CAB_OP_ADC        = 6'h02,
    CAB_OP_ADD_IMM_W  = 6'h03,
    CAB_OP_SUB        = 6'h04,
    CAB_OP_SUB_IMM    = 6'h05,
    CAB_OP_SUB_RC     = 6'h06,
    CAB_OP_SUB_IMM_C  = 6'h07,
    CAB_OP_SUB_IMM_W  = 6'h08,
    CAB_OP_AND        = 6'h09,
    CAB_OP_AND_IMM    = 6'h0a,
    CAB_OP_OR         = 6'h0b,
    CAB_OP_OR_IMM     = 6'h0c,
    CAB_OP_XOR        = 6'h0d,
    CAB_OP_ONES       = 6'h0e,
    CAB_OP_NEG        = 6'h0f,
    CAB_OP_SET_BITS   = 6'h10,
    CAB_OP_CLR_MASK   = 6'h11,
    CAB_OP_INC        = 6'h12,
    CAB_OP_DEC        = 6'h13,
    CAB_OP_TEST       = 6'h14,
    CAB_OP_CLR        = 6'h15,
    CAB_OP_SET_REG    = 6'h16,
    CAB_OP_MUL_U      = 6'h17,
    CAB_OP_MUL_S      = 6'h18,
    CAB_OP_MUL_SU     = 6'h19,
    CAB_OP_FRAC_MULT_UNSIGNED_U     = 6'h1a,
    CAB_OP_FRAC_MULT_UNSIGNED_S     = 6'h1b,
    CAB_OP_FRAC_MULT_UNSIGNED_SU    = 6'h1c,
    CAB_OP_REL_JUMP   = 6'h1d,
    CAB_OP_IND_JUMP   = 6'h1e,
    CAB_OP_ABS_JUMP   = 6'h1f,
    CAB_OP_REL_CALL   = 6'h20,
    CAB_OP_IND_CALL   = 6'h21,
    CAB_OP_ABS_CALL   = 6'h22,
    CAB_OP_RET        = 6'h23,
    CAB_OP_IRQ_RET    = 6'h24,
    CAB_OP_CMP_SKIP   = 6'h25,
    CAB_OP_CMP        = 6'h26,
    CAB_OP_CMP_CARRY  = 6'h27
  } cab_op_t;

  // status flag bit positions in the 8-bit status byte
  localparam int CAB_FLAG_C = 0;
  localparam int CAB_FLAG_Z = 1;
  localparam int CAB_FLAG_N = 2;
  localparam int CAB_FLAG_V = 3;
  localparam int CAB_FLAG_S = 4;
  localparam int CAB_FLAG_H = 5;
  localparam int CAB_FLAG_I = 7;

  // cycle counts per instruction class
  localparam logic [2:0] CAB_CYC_1 = 3'h1;
  localparam logic [2:0] CAB_CYC_2 = 3'h2;
  localparam logic [2:0] CAB_CYC_3 = 3'h3;
  localparam logic [2:0] CAB_CYC_4 = 3'h4;

  // program counter steps
  localparam logic [15:0] CAB_PC_STEP1 = 16'h0001;
  localparam logic [15:0] CAB_PC_STEP2 = 16'h0002;
  localparam logic [15:0] CAB_PC_STEP3 = 16'h0003;

  // constant patterns
  localparam logic [7:0] CAB_ALL_ONES = 8'hff;
  localparam logic [7:0] CAB_ZERO     = 8'h00;

  // one instruction issued by the decoder
  typedef struct packed {
    cab_op_t     op;        // operation
    logic [7:0]  rd;        // destination operand value (low byte of pair)
    logic [7:0]  rd_hi;     // high byte of a register pair
    logic [7:0]  rr;        // source register or immediate constant
    logic [15:0] target;    // offset, absolute target or z pointer
    logic [15:0] pc;        // address of this instruction
    logic        next_long; // following instruction is two words
  } cab_issue_t;

  // result handed back to the core
  typedef struct packed {
    logic        wr_rd;     // write result byte to destination
    logic        wr_pair;   // write 16-bit result to pair / r1:r0
    logic        wr_r10;    // pair is r1:r0 (multiplier)
    logic [15:0] result;    // result word (low byte for byte ops)
    logic        pc_load;   // program counter takes new_pc
    logic [15:0] new_pc;    // new program counter
    logic        push_ret;  // push return address (calls)
    logic        pop_ret;   // pop return address (returns)
    logic [7:0]  sreg;      // status byte after this instruction
  } cab_result_t;

endpackage

// ### design/cab_mult.sv
// 8x8 multiplier covering unsigned, signed, mixed and fractional forms
`timescale 1ns/1ns
module cab_mult
  import cab_pkg::*;
(
  input  wire logic [7:0]  a,        // multiplicand (rd)
  input  wire logic [7:0]  b,        // multiplier (rr)
  input  wire logic        a_signed, // rd taken as signed
  input  wire logic        b_signed, // rr taken as signed
  input  wire logic        frac,     // shift product left by one
  output logic      [15:0] product,  // product as written to r1:r0
  output logic             carry     // bit 15 of the unshifted product
);

  logic signed [17:0] full;  // 9x9 signed product covers all forms
  logic        [15:0] raw;   // product before fractional shift

  // extend each operand by its own sign choice, then one signed multiply
  always_comb begin
    full    = $signed({a_signed & a[7], a}) * $signed({b_signed & b[7], b});
    raw     = full[15:0];
    carry   = raw[15];
    // fractional forms drop the top bit to keep the binary point
    product = frac ? {raw[14:0], 1'b0} : raw;
  end

endmodule

// ### design/cab_execute.sv
// execute stage for arithmetic, logic, multiply, jump, call and skip
`timescale 1ns/1ns
module cab_execute
  import cab_pkg::*;
(
  input  wire logic        sys_clk,     // core clock, 250 MHz
  input  wire logic        reset_n,     // asynchronous reset, active low
  input  wire logic        issue_valid, // decoder presents an instruction
  input  wire cab_issue_t  issue,       // instruction and operands
  input  wire logic [7:0]  sreg_in,     // current status byte
  input  wire logic [15:0] ret_addr,    // popped return address
  output logic             issue_ready, // unit can take an instruction
  output logic             done,        // one-cycle result strobe
  output cab_result_t      res          // result, valid with done
);

  // execution sequencer states
  typedef enum logic [1:0] {
    CAB_ST_IDLE = 2'b01,
    CAB_ST_BUSY = 2'b10
  } cab_state_t;

  logic        rst_meta;   // reset release stage one
  logic        rst_sync_n; // reset released through two flops
  cab_state_t  state;      // sequencer state
  logic [2:0]  cyc_left;   // remaining cycles of this instruction
  cab_result_t held;       // result computed at issue, held till done
  cab_result_t next_res;   // combinational result of the issue
  logic [2:0]  next_cyc;   // cycle count of the issue
  logic [15:0] mprod;      // multiplier product
  logic        mcarry;     // multiplier carry
  logic        m_as;       // rd signed
  logic        m_bs;       // rr signed
  logic        m_fr;       // fractional

  // status update for 8-bit add/sub: returns {h,v,n,z,c}
  function automatic logic [4:0] cab_flags8(
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] r,
    input logic sub, input logic keep_z);
    logic c;
    logic h;
    logic v;
    logic z;
    c = sub ? ((~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]))
            : ((a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]));
    h = sub ? ((~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]))
            : ((a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]));
    v = sub ? ((a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]))
            : ((a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]));
    // carry-chained forms keep Z clear unless the result stays zero
    z = (r == CAB_ZERO) & keep_z;
    return {h, v, r[7], z, c};
  endfunction

  // place flags into a status byte: S is always N xor V
  function automatic logic [7:0] cab_put(
    input logic [7:0] s, input logic [4:0] f, input logic upd_h,
    input logic upd_c);
    logic [7:0] o;
    o = s;
    if (upd_c) begin
      o[CAB_FLAG_C] = f[0];
    end
    o[CAB_FLAG_Z] = f[1];
    o[CAB_FLAG_N] = f[2];
    o[CAB_FLAG_V] = f[3];
    o[CAB_FLAG_S] = f[2] ^ f[3];
    if (upd_h) begin
      o[CAB_FLAG_H] = f[4];
    end
    return o;
  endfunction

  // multiplier mode select
  always_comb begin
    m_as = issue.op inside {CAB_OP_MUL_S, CAB_OP_MUL_SU, CAB_OP_FRAC_MULT_UNSIGNED_S,
                            CAB_OP_FRAC_MULT_UNSIGNED_SU};
    m_bs = issue.op inside {CAB_OP_MUL_S, CAB_OP_FRAC_MULT_UNSIGNED_S};
    m_fr = issue.op inside {CAB_OP_FRAC_MULT_UNSIGNED_U, CAB_OP_FRAC_MULT_UNSIGNED_S, CAB_OP_FRAC_MULT_UNSIGNED_SU};
  end

  cab_mult u_mult (
    .a        (issue.rd),
    .b        (issue.rr),
    .a_signed (m_as),
    .b_signed (m_bs),
    .frac     (m_fr),
    .product  (mprod),
    .carry    (mcarry)
  );

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // compute result, flags, program counter and cycle count of an issue
  always_comb begin
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  r;
    logic [15:0] w;
    logic [15:0] w_in;
    logic        cin;
    logic [15:0] pc1;
    logic [15:0] skip_pc;
    a        = issue.rd;
    b        = issue.rr;
    r        = CAB_ZERO;
    w_in     = {issue.rd_hi, issue.rd};
    w        = 16'h0000;
    cin      = sreg_in[CAB_FLAG_C];
    pc1      = issue.pc + CAB_PC_STEP1;
    skip_pc  = issue.pc + (issue.next_long ? CAB_PC_STEP3 : CAB_PC_STEP2);
    next_res = '0;
    next_res.sreg   = sreg_in;
    next_res.new_pc = pc1;
    next_cyc = CAB_CYC_1;
    unique case (issue.op)
      CAB_OP_ADD, CAB_OP_ADC: begin
        r = a + b + {7'h00, (issue.op == CAB_OP_ADC) & cin};
        next_res.wr_rd = 1'b1;
        next_res.sreg  = cab_put(sreg_in, cab_flags8(a, b, r, 1'b0, 1'b1),
                                 1'b1, 1'b1);
      end
      CAB_OP_SUB, CAB_OP_SUB_IMM, CAB_OP_CMP: begin
        r = a - b;
        // compare writes nothing back
        next_res.wr_rd = issue.op != CAB_OP_CMP;
        next_res.sreg  = cab_put(sreg_in, cab_flags8(a, b, r, 1'b1, 1'b1),
                                 1'b1, 1'b1);
      end
      CAB_OP_SUB_RC, CAB_OP_SUB_IMM_C, CAB_OP_CMP_CARRY: begin
        r = a - b - {7'h00, cin};
        next_res.wr_rd = issue.op != CAB_OP_CMP_CARRY;
        // zero flag only stays set across a chain of zero bytes
        next_res.sreg  = cab_put(sreg_in,
          cab_flags8(a, b, r, 1'b1, sreg_in[CAB_FLAG_Z]), 1'b1, 1'b1);
      end
      CAB_OP_ADD_IMM_W, CAB_OP_SUB_IMM_W: begin
        // word forms: 16-bit result, S written with the others
        w = (issue.op == CAB_OP_ADD_IMM_W) ? w_in + {8'h00, b}
                                           : w_in - {8'h00, b};
        next_res.wr_pair = 1'b1;
        next_cyc = CAB_CYC_2;
        next_res.sreg = cab_put(sreg_in, {1'b0,
          (issue.op == CAB_OP_ADD_IMM_W) ? (~w_in[15] & w[15])
                                         : (w_in[15] & ~w[15]),
          w[15], w == 16'h0000,
          (issue.op == CAB_OP_ADD_IMM_W) ? (w_in[15] & ~w[15])
                                         : (~w_in[15] & w[15])},
          1'b0, 1'b1);
      end
      CAB_OP_AND, CAB_OP_AND_IMM, CAB_OP_OR, CAB_OP_OR_IMM, CAB_OP_XOR,
      CAB_OP_SET_BITS, CAB_OP_CLR_MASK, CAB_OP_TEST, CAB_OP_CLR: begin
        unique case (issue.op)
          CAB_OP_AND, CAB_OP_AND_IMM: r = a & b;
          CAB_OP_OR, CAB_OP_OR_IMM, CAB_OP_SET_BITS: r = a | b;
          CAB_OP_XOR: r = a ^ b;
          CAB_OP_CLR_MASK: r = a & (CAB_ALL_ONES - b);
          CAB_OP_TEST: r = a & a;
          default: r = a ^ a;
        endcase
        // test leaves the register alone, only the flags move
        next_res.wr_rd = issue.op != CAB_OP_TEST;
        next_res.sreg  = cab_put(sreg_in, {1'b0, 1'b0, r[7],
                                 r == CAB_ZERO, 1'b0}, 1'b0, 1'b0);
      end
      CAB_OP_INC, CAB_OP_DEC: begin
        r = (issue.op == CAB_OP_INC) ? a + 8'h01 : a - 8'h01;
        next_res.wr_rd = 1'b1;
        // overflow only at the signed wrap point
        next_res.sreg = cab_put(sreg_in, {1'b0,
          (issue.op == CAB_OP_INC) ? (r == 8'h80) : (r == 8'h7f),
          r[7], r == CAB_ZERO, 1'b0}, 1'b0, 1'b0);
      end
      CAB_OP_ONES: begin
        r = CAB_ALL_ONES - a;
        next_res.wr_rd = 1'b1;
        next_res.sreg  = cab_put(sreg_in, {1'b0, 1'b0, r[7],
                                 r == CAB_ZERO, 1'b1}, 1'b0, 1'b1);
      end
      CAB_OP_NEG: begin
        r = CAB_ZERO - a;
        next_res.wr_rd = 1'b1;
        next_res.sreg  = cab_put(sreg_in,
          cab_flags8(CAB_ZERO, a, r, 1'b1, 1'b1), 1'b1, 1'b1);
      end
      CAB_OP_SET_REG: begin
        r = CAB_ALL_ONES;
        next_res.wr_rd = 1'b1;
      end
      CAB_OP_MUL_U, CAB_OP_MUL_S, CAB_OP_MUL_SU,
      CAB_OP_FRAC_MULT_UNSIGNED_U, CAB_OP_FRAC_MULT_UNSIGNED_S, CAB_OP_FRAC_MULT_UNSIGNED_SU: begin
        w = mprod;
        next_res.wr_pair = 1'b1;
        next_res.wr_r10  = 1'b1;
        next_cyc = CAB_CYC_2;
        next_res.sreg[CAB_FLAG_Z] = mprod == 16'h0000;
        next_res.sreg[CAB_FLAG_C] = mcarry;
      end
      CAB_OP_REL_JUMP, CAB_OP_REL_CALL: begin
        next_res.pc_load  = 1'b1;
        next_res.new_pc   = pc1 + issue.target;
        next_res.push_ret = issue.op == CAB_OP_REL_CALL;
        next_cyc = (issue.op == CAB_OP_REL_CALL) ? CAB_CYC_3
                                                 : CAB_CYC_2;
      end
      CAB_OP_IND_JUMP, CAB_OP_IND_CALL: begin
        next_res.pc_load  = 1'b1;
        next_res.new_pc   = issue.target;
        next_res.push_ret = issue.op == CAB_OP_IND_CALL;
        next_cyc = (issue.op == CAB_OP_IND_CALL) ? CAB_CYC_3
                                                 : CAB_CYC_2;
      end
      CAB_OP_ABS_JUMP, CAB_OP_ABS_CALL: begin
        next_res.pc_load  = 1'b1;
        next_res.new_pc   = issue.target;
        next_res.push_ret = issue.op == CAB_OP_ABS_CALL;
        next_cyc = (issue.op == CAB_OP_ABS_CALL) ? CAB_CYC_4
                                                 : CAB_CYC_3;
      end
      CAB_OP_RET, CAB_OP_IRQ_RET: begin
        next_res.pc_load = 1'b1;
        next_res.new_pc  = ret_addr;
        next_res.pop_ret = 1'b1;
        next_cyc = CAB_CYC_4;
        // interrupt return re-enables interrupts globally
        if (issue.op == CAB_OP_IRQ_RET) begin
          next_res.sreg[CAB_FLAG_I] = 1'b1;
        end
      end
      CAB_OP_CMP_SKIP: begin
        // equal: skip one or two words, flags untouched
        if (a == b) begin
          next_res.pc_load = 1'b1;
          next_res.new_pc  = skip_pc;
          next_cyc = issue.next_long ? CAB_CYC_3 : CAB_CYC_2;
        end
      end
      default: begin
        next_cyc = CAB_CYC_1;
      end
    endcase
    // byte results sit in the low byte of the word
    next_res.result = (next_res.wr_pair) ? w : {8'h00, r};
  end

  // sequencer: take an issue, count its cycles, strobe done at the end
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state    <= CAB_ST_IDLE;
      cyc_left <= 3'h0;
      held     <= '0;
    end else begin
      unique case (state)
        CAB_ST_IDLE: begin
          if (issue_valid) begin
            held     <= next_res;
            cyc_left <= next_cyc;
            state    <= CAB_ST_BUSY;
          end
        end
        CAB_ST_BUSY: begin
          if (cyc_left == CAB_CYC_1) begin
            state <= CAB_ST_IDLE;
          end
          cyc_left <= cyc_left - 3'h1;
        end
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      done        <= 1'b0;
      res         <= '0;
      issue_ready <= 1'b0;
    end else begin
      // done pulses in the cycle after the last counted cycle of the instruction
      done        <= (state == CAB_ST_BUSY) && (cyc_left == CAB_CYC_1);
      res         <= held;
      // ready when idle and not just taking an issue, or busy in the last counted cycle
      issue_ready <= ((state == CAB_ST_IDLE) && !issue_valid) ||
                     ((state == CAB_ST_BUSY) && (cyc_left == CAB_CYC_1));
    end
  end

endmodule

// ### verification/cab_execute_chk.sv
// assertion checker for the arithmetic and branch execute unit
`timescale 1ns/1ns
module cab_execute_chk
  import cab_pkg::*;
(
  input  wire logic        sys_clk,     // core clock
  input  wire logic        reset_n,     // async reset, active low
  input  wire logic        issue_valid, // instruction presented
  input  wire cab_issue_t  issue,       // instruction and operands
  input  wire logic [7:0]  sreg_in,     // status byte at issue
  input  wire logic        issue_ready, // unit idle
  input  wire logic        done,        // one-cycle result strobe
  input  wire cab_result_t res          // result, valid with done
);
  logic       take;  // instruction accepted on this edge
  cab_issue_t cap;   // operands of the accepted instruction
  logic [7:0] cap_s; // status byte seen at acceptance

  assign take = issue_valid && issue_ready;

  // keep the operands so the answer can be judged when done pulses
  always_ff @(posedge sys_clk) begin
    if (take) begin
      cap   <= issue;
      cap_s <= sreg_in;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_lat1;
    take && issue.op inside {CAB_OP_ADD, CAB_OP_SUB, CAB_OP_CMP}
      |-> ##1 (!done)[*1] ##1 done;
  endproperty
  a_lat1: assert property (p_lat1) else $error("one-cycle op late");
  property p_lat2;
    take && issue.op inside {CAB_OP_ADD_IMM_W, CAB_OP_MUL_U}
      |-> ##1 (!done)[*2] ##1 done;
  endproperty
  a_lat2: assert property (p_lat2) else $error("two-cycle op late");
  property p_lat4;
    take && issue.op == CAB_OP_ABS_CALL |-> ##1 (!done)[*4] ##1 done;
  endproperty
  a_lat4: assert property (p_lat4) else $error("direct call late");
  property p_add;
    done && cap.op == CAB_OP_ADD
      |-> res.wr_rd && res.result[7:0] == cap.rd + cap.rr;
  endproperty
  a_add: assert property (p_add) else $error("sum wrong");
  property p_logic;
    done && cap.op inside {CAB_OP_AND, CAB_OP_OR, CAB_OP_XOR}
      |-> res.sreg[CAB_FLAG_C] == cap_s[CAB_FLAG_C];
  endproperty
  a_logic: assert property (p_logic) else $error("logic op hit C");
  property p_neg;
    done && cap.op == CAB_OP_NEG |-> res.result[7:0] == 8'h00 - cap.rd;
  endproperty
  a_neg: assert property (p_neg) else $error("negate wrong");
  property p_mul;
    done && cap.op == CAB_OP_MUL_U
      |-> res.wr_r10 && res.result == cap.rd * cap.rr;
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong");
  property p_rel_jump;
    done && cap.op == CAB_OP_REL_JUMP
      |-> res.pc_load && res.new_pc == cap.pc + cap.target + 16'h0001;
  endproperty
  a_rel_jump: assert property (p_rel_jump) else $error("jump target wrong");
  property p_skip;
    done && cap.op == CAB_OP_CMP_SKIP |-> res.sreg == cap_s;
  endproperty
  a_skip: assert property (p_skip) else $error("skip moved flags");
  property p_cmp;
    done && cap.op inside {CAB_OP_CMP, CAB_OP_CMP_CARRY}
      |-> !res.wr_rd && !res.wr_pair;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrote");
endmodule

bind cab_execute cab_execute_chk u_chk (
  .sys_clk     (sys_clk),
  .reset_n     (reset_n),
  .issue_valid (issue_valid),
  .issue       (issue),
  .sreg_in     (sreg_in),
  .issue_ready (issue_ready),
  .done        (done),
  .res         (res)
);

// ### verification/cab_execute_bench.sv
// self-checking bench for the arithmetic and branch execute unit
`timescale 1ns/1ns
module cab_execute_bench
  import cab_pkg::*;
;
  logic        sys_clk     = 1'b0;     // core clock, 4 ns
  logic        reset_n     = 1'b0;     // reset, active low
  logic        issue_valid = 1'b0;     // instruction presented
  cab_issue_t  issue       = '0;       // instruction and operands
  logic [7:0]  sreg_in     = 8'h00;    // status byte in
  logic [15:0] ret_addr    = 16'h0abc; // popped return address
  logic        issue_ready;            // unit idle
  logic        done;                   // result strobe
  cab_result_t res;                    // result
  int          n_mismatch  = 0;        // mismatches seen
  int          n_compared  = 0;        // comparisons made
  int          cyc;                    // measured cycle count

  always #2 sys_clk = ~sys_clk;

  cab_execute u_dut (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .issue_valid (issue_valid),
    .issue       (issue),
    .sreg_in     (sreg_in),
    .ret_addr    (ret_addr),
    .issue_ready (issue_ready),
    .done        (done),
    .res         (res)
  );

  // one edge, then settle so inputs never move on the edge
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  // judge one value against its expectation
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // issue when idle; cycle count is edges from the taking edge to done
  task automatic run(cab_op_t op, logic [7:0] a, logic [7:0] h,
                     logic [7:0] b, logic [15:0] t, logic [15:0] p,
                     logic nl, logic [7:0] s);
    int i;
    for (i = 0; i < 20 && issue_ready !== 1'b1; i++) tick();
    issue = '{op, a, h, b, t, p, nl};
    sreg_in = s;
    issue_valid = 1'b1;
    tick();
    issue_valid = 1'b0;
    for (cyc = 0; cyc < 20 && done !== 1'b1; cyc++) tick();
  endtask

  // byte operation: result, masked flags, one cycle
  task automatic byte_op(cab_op_t op, logic [7:0] a, logic [7:0] b,
                         logic [7:0] s, logic [7:0] r, logic [7:0] m,
                         logic [7:0] f);
    run(op, a, 8'h00, b, 16'h0000, 16'h0000, 1'b0, s);
    cmp("result", {8'h00, r}, {8'h00, res.result[7:0]});
    cmp("flags", {8'h00, f}, {8'h00, res.sreg & m});
    cmp("cycles", 16'h0001, 16'(cyc));
    // ready comes back with the same edge that raises done
    cmp("ready", 16'h0001, {15'h0, issue_ready});
  endtask

  // word immediate operation on a register pair, two cycles
  task automatic word_op(cab_op_t op, logic [15:0] a, logic [7:0] k,
                         logic [15:0] r, logic [7:0] f);
    run(op, a[7:0], a[15:8], k, 16'h0000, 16'h0000, 1'b0, 8'h00);
    cmp("word", r, res.result);
    cmp("pair", 16'h0001, {15'h0, res.wr_pair});
    cmp("wflags", {8'h00, f}, {8'h00, res.sreg & 8'h1f});
    cmp("wcycles", 16'h0002, 16'(cyc));
  endtask

  // multiply into r1:r0, flags Z and C, two cycles
  task automatic mul_op(cab_op_t op, logic [7:0] a, logic [7:0] b,
                        logic [15:0] r, logic [7:0] f);
    run(op, a, 8'h00, b, 16'h0000, 16'h0000, 1'b0, 8'h00);
    cmp("product", r, res.result);
    cmp("r10", 16'h0001, {15'h0, res.wr_r10});
    cmp("mflags", {8'h00, f}, {8'h00, res.sreg & 8'h03});
    cmp("mcycles", 16'h0002, 16'(cyc));
  endtask

  // jump, call or return from address 0100
  task automatic br_op(cab_op_t op, logic [15:0] t, logic [15:0] pc,
                       logic [2:0] n, logic c);
    run(op, 8'h00, 8'h00, 8'h00, t, 16'h0100, 1'b0, 8'h00);
    cmp("pc", pc, res.new_pc);
    cmp("load", 16'h0001, {15'h0, res.pc_load});
    cmp("push", {15'h0, c}, {15'h0, res.push_ret});
    cmp("bcycles", {13'h0, n}, 16'(cyc));
  endtask

  task automatic t_add;
    byte_op(CAB_OP_ADD, 8'h7f, 8'h01, 8'h00, 8'h80, 8'h2f, 8'h2c);
    byte_op(CAB_OP_ADC, 8'hff, 8'h00, 8'h01, 8'h00, 8'h2f, 8'h23);
  endtask

  task automatic t_sub;
    byte_op(CAB_OP_SUB, 8'h10, 8'h20, 8'h00, 8'hf0, 8'h2f, 8'h05);
    byte_op(CAB_OP_SUB_IMM, 8'h10, 8'h20, 8'h00, 8'hf0, 8'h2f,
            8'h05);
    byte_op(CAB_OP_SUB_RC, 8'h00, 8'h00, 8'h03, 8'hff, 8'h2f,
            8'h25);
    byte_op(CAB_OP_SUB_IMM_C, 8'h00, 8'h00, 8'h03, 8'hff, 8'h2f,
            8'h25);
    byte_op(CAB_OP_SUB_RC, 8'h05, 8'h05, 8'h00, 8'h00, 8'h2f,
            8'h00);
    byte_op(CAB_OP_SUB_RC, 8'h05, 8'h05, 8'h02, 8'h00, 8'h2f,
            8'h02);
  endtask

  // carry and half carry stand, overflow is cleared
  task automatic t_logic;
    byte_op(CAB_OP_AND, 8'hf0, 8'h8f, 8'h29, 8'h80, 8'h2f, 8'h25);
    byte_op(CAB_OP_AND_IMM, 8'hf0, 8'h8f, 8'h29, 8'h80, 8'h2f,
            8'h25);
    byte_op(CAB_OP_OR, 8'h00, 8'h00, 8'h29, 8'h00, 8'h2f, 8'h23);
    byte_op(CAB_OP_OR_IMM, 8'h00, 8'h00, 8'h29, 8'h00, 8'h2f,
            8'h23);
    byte_op(CAB_OP_XOR, 8'h80, 8'h80, 8'h29, 8'h00, 8'h2f, 8'h23);
  endtask

  task automatic t_unary;
    byte_op(CAB_OP_ONES, 8'h00, 8'h00, 8'h00, 8'hff, 8'h0f, 8'h05);
    byte_op(CAB_OP_NEG, 8'h01, 8'h00, 8'h00, 8'hff, 8'h2f, 8'h25);
    byte_op(CAB_OP_NEG, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2f, 8'h02);
    byte_op(CAB_OP_CLR_MASK, 8'hff, 8'h0f, 8'h08, 8'hf0, 8'h0e,
            8'h04);
    byte_op(CAB_OP_TEST, 8'h80, 8'h00, 8'h08, 8'h80, 8'h0e, 8'h04);
    byte_op(CAB_OP_TEST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h02);
    // test must leave the register untouched
    cmp("twrite", 16'h0000, {15'h0, res.wr_rd});
  endtask

  task automatic t_word;
    word_op(CAB_OP_ADD_IMM_W, 16'hffff, 8'h01, 16'h0000, 8'h03);
    word_op(CAB_OP_ADD_IMM_W, 16'h7fff, 8'h01, 16'h8000, 8'h0c);
    word_op(CAB_OP_SUB_IMM_W, 16'h0000, 8'h01, 16'hffff, 8'h15);
  endtask

  task automatic t_mul;
    mul_op(CAB_OP_MUL_U, 8'hff, 8'hff, 16'hfe01, 8'h01);
    mul_op(CAB_OP_MUL_U, 8'h00, 8'h37, 16'h0000, 8'h02);
    mul_op(CAB_OP_MUL_S, 8'hff, 8'hff, 16'h0001, 8'h00);
    mul_op(CAB_OP_MUL_SU, 8'hff, 8'h02, 16'hfffe, 8'h01);
    mul_op(CAB_OP_FRAC_MULT_UNSIGNED_U, 8'h80, 8'h80, 16'h8000, 8'h00);
    mul_op(CAB_OP_FRAC_MULT_UNSIGNED_S, 8'h80, 8'h80, 16'h8000, 8'h00);
    mul_op(CAB_OP_FRAC_MULT_UNSIGNED_SU, 8'hff, 8'h80, 16'hff00, 8'h01);
  endtask

  task automatic t_branch;
    br_op(CAB_OP_REL_JUMP, 16'h0010, 16'h0111, CAB_CYC_2, 1'b0);
    br_op(CAB_OP_REL_JUMP, 16'hfff0, 16'h00f1, CAB_CYC_2, 1'b0);
    br_op(CAB_OP_REL_CALL, 16'h0010, 16'h0111, CAB_CYC_3, 1'b1);
    br_op(CAB_OP_IND_JUMP, 16'h1234, 16'h1234, CAB_CYC_2, 1'b0);
    br_op(CAB_OP_IND_CALL, 16'h1234, 16'h1234, CAB_CYC_3, 1'b1);
    br_op(CAB_OP_ABS_JUMP, 16'h2000, 16'h2000, CAB_CYC_3, 1'b0);
    br_op(CAB_OP_ABS_CALL, 16'h2000, 16'h2000, CAB_CYC_4, 1'b1);
    br_op(CAB_OP_IRQ_RET, 16'h0000, 16'h0abc, CAB_CYC_4, 1'b0);
    cmp("ibit", 16'h0080, {8'h00, res.sreg & 8'h80});
    cmp("pop", 16'h0001, {15'h0, res.pop_ret});
  endtask

  // equal operands skip one or two words, unequal falls through
  task automatic t_skip;
    run(CAB_OP_CMP_SKIP, 8'h05, 8'h00, 8'h05, 16'h0, 16'h0100, 1'b0,
        8'h2b);
    cmp("skip1", 16'h0102, res.new_pc);
    cmp("scyc1", 16'h0002, 16'(cyc));
    run(CAB_OP_CMP_SKIP, 8'h05, 8'h00, 8'h05, 16'h0, 16'h0100, 1'b1,
        8'h2b);
    cmp("skip2", 16'h0103, res.new_pc);
    cmp("scyc2", 16'h0003, 16'(cyc));
    run(CAB_OP_CMP_SKIP, 8'h05, 8'h00, 8'h06, 16'h0, 16'h0100, 1'b0,
        8'h2b);
    cmp("scyc0", 16'h0001, 16'(cyc));
    cmp("sflags", 16'h002b, {8'h00, res.sreg});
  endtask

  // compares set flags and write nothing
  task automatic t_cmp;
    run(CAB_OP_CMP, 8'h10, 8'h00, 8'h20, 16'h0, 16'h0, 1'b0, 8'h00);
    cmp("cflags", 16'h0005, {8'h00, res.sreg & 8'h2f});
    cmp("cwrite", 16'h0000, {15'h0, res.wr_rd});
    run(CAB_OP_CMP_CARRY, 8'h00, 8'h00, 8'h00, 16'h0, 16'h0, 1'b0,
        8'h03);
    cmp("ccflags", 16'h0025, {8'h00, res.sreg & 8'h2f});
    cmp("ccwrite", 16'h0000, {15'h0, res.wr_rd});
  endtask

  // print the counts and the verdict, then stop
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_add();
    t_sub();
    t_logic();
    t_unary();
    t_word();
    t_mul();
    t_branch();
    t_skip();
    t_cmp();
    final_report();
  end

  // watchdog: the whole sequence needs well under 2000 ns
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
endmodule
